// [rtl/nibble_core.sv]
// Nibble processor core: fetch, decode and execute with APB control
//
// Functional notes
// (RULE_01) Each word splits into upper operation and lower modifier nibbles, upper first.
// (RULE_02) One-word instructions take eight clocks, two-word instructions sixteen.
// (RULE_03) Three-bit field picks one of eight pairs; four-bit field one of sixteen.
// (RULE_04) Conditional jump: op 0001, four condition bits, in-page target in word two.
// (RULE_05) Condition bit one inverts; others test accumulator zero, carry, test input.
// (RULE_06) Immediate pair fetch loads the second word into the selected pair.
// (RULE_07) Register control send emits pair contents as chip, register, character.
// (RULE_08) Indirect pair fetch loads program word addressed by pair zero.
// (RULE_09) Jump via pair replaces low eight counter bits with pair contents.
// (RULE_10) Jump and call form a 12-bit target; call pushes return address.
// (RULE_11) Increment-skip increments register, jumps in page when result nonzero.
// (RULE_12) Add register plus carry; subtract register with borrow, carry updated.
// (RULE_13) Load register into accumulator; swap accumulator and register.
// (RULE_14) Return and load modifier into accumulator; or load without return.
// (RULE_15) Bank codes 0A, 0B select index banks; 09 designates ROM bank one.
// (RULE_16) I/O modifiers 1011 add and 1000 subtract the RAM character.
// (RULE_17) I/O modifiers 1001 read RAM character, 1010 read ROM input port.
// (RULE_18) I/O modifiers 1100 to 1111 read status characters zero to three.
// (RULE_19) RAM chips hold four registers of sixteen plus four status characters.
// (RULE_20) Accumulator codes 0 to 3: clear both, clear carry, increment, flip carry.
// (RULE_21) Codes 5 and 6 rotate the 5-bit ring; code 7 moves carry, clears it.
// (RULE_22) Code 8 decrements accumulator; code 9 loads subtract-carry value, clears carry.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ns
module nibble_core
  import nibble_core_pkg::*;
#(
  parameter int STACK_DEPTH = 7
) (
  input  wire logic        sys_clk,       // 10 MHz system clock
  input  wire logic        rst_n,         // Synchronous reset, active low
  input  wire logic        psel,          // APB select
  input  wire logic        penable,       // APB access phase
  input  wire logic        pwrite,        // APB write
  input  wire logic [7:0]  paddr,         // APB byte address
  input  wire logic [31:0] pwdata,        // APB write data
  output logic      [31:0] prdata,        // APB read data
  output logic             pready,        // APB ready
  output logic             pslverr,       // APB error on unmapped address
  output logic      [11:0] rom_addr,      // Program memory address
  input  wire logic [7:0]  rom_data,      // Program memory word
  output src_addr_s        src_addr,      // Sent chip, register, character
  output io_req_s          io_req,        // RAM/ROM read request and code
  input  wire logic [3:0]  io_data,       // RAM/ROM read data
  input  wire logic        test_in,       // External test input
  output logic             rom_bank_sel,  // Designated ROM bank
  output logic             carry_out,     // Carry flag
  output logic             sync_out       // Start of instruction cycle
);
  // -----------------------------------------------------------
  // State
  // -----------------------------------------------------------
  core_state_e state;
  logic [2:0]  ph;
  logic [3:0]  operation_field;
  logic [3:0]  modifier_field;
  logic [7:0]  word2;
  logic [3:0]  acc;
  logic        cy;
  logic        bank;
  logic [11:0] pc;
  logic [11:0] stack [0:STACK_DEPTH-1];
  logic [2:0]  sp;
  logic [3:0]  idx [0:1][0:15];
  logic        run;

  // Decode helpers
  logic        two_word;
  logic        exec1;
  logic        exec2;
  logic        fin_second;
  logic [3:0]  reg_val;
  logic [7:0]  pair_val;
  logic [7:0]  pair0_val;
  logic [3:0]  alu_b;
  logic [4:0]  add_res;
  logic [4:0]  sub_res;
  logic [3:0]  inc_res;
  logic        cond;
  logic        jump_taken;
  logic [2:0]  sp_up;
  logic [2:0]  sp_dn;

  // -----------------------------------------------------------
  // Decode
  // -----------------------------------------------------------
  // Pair bits select the pair; all four bits select a register
  assign reg_val   = idx[bank][modifier_field];                    // [RULE_03]
  assign pair_val  = {idx[bank][{modifier_field[3:1], 1'b0}],
                      idx[bank][{modifier_field[3:1], 1'b1}]};     // [RULE_03]
  assign pair0_val = {idx[bank][4'h0], idx[bank][4'h1]};

  // Second word needed for jumps, call, skip and fetches
  always_comb begin
    unique case (operation_field)
      OP_JCN, OP_JUN, OP_JMS, OP_ISZ: two_word = 1'b1;  // [RULE_02]
      OP_PAIR, OP_IND:  two_word = ~modifier_field[0];             // [RULE_02]
      default:          two_word = 1'b0;
    endcase
  end

  assign exec1 = (state == ST_FETCH) && (ph == PH_EXEC) && !two_word;
  assign exec2 = (state == ST_SECOND) && (ph == PH_EXEC);
  // Indirect fetch uses its second cycle to read through pair zero
  assign fin_second = (operation_field == OP_IND) && !modifier_field[0];

  // Memory character for I/O group, register otherwise
  assign alu_b   = (operation_field == OP_IO) ? io_data : reg_val;
  assign add_res = {1'b0, acc} + {1'b0, alu_b} + {4'h0, cy};
  // Borrow form: carry set afterwards means no borrow
  assign sub_res = {1'b0, acc} + {1'b0, ~alu_b} + {4'h0, ~cy};
  assign inc_res = reg_val + 4'h1;

  // Condition: bit3 inverts, bit2 acc zero, bit1 carry, bit0 test low
  assign cond = (modifier_field[2] && (acc == 4'h0)) || (modifier_field[1] && cy)
             || (modifier_field[0] && !test_in);                   // [RULE_05]
  assign jump_taken = cond ^ modifier_field[3];                    // [RULE_05]

  assign sp_up = (sp == 3'(STACK_DEPTH - 1)) ? 3'h0 : sp + 3'h1;
  assign sp_dn = (sp == 3'h0) ? 3'(STACK_DEPTH - 1) : sp - 3'h1;

  // -----------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------
  // Eight phases per word; a second word adds eight more
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state    <= ST_IDLE;
      ph       <= PH_ADDR;
      sync_out <= 1'b0;
    end else begin
      sync_out <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (run) begin
            state    <= ST_FETCH;
            ph       <= PH_ADDR;
            sync_out <= 1'b1;
          end
        end
        ST_FETCH, ST_SECOND: begin
          ph <= ph + 3'h1;
          if (ph == PH_EXEC) begin
            if (state == ST_FETCH && two_word) begin
              state    <= ST_SECOND;               // [RULE_02]
              sync_out <= 1'b1;
            end else if (run) begin
              state    <= ST_FETCH;
              sync_out <= 1'b1;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // -----------------------------------------------------------
  // Instruction capture
  // -----------------------------------------------------------
  // Operation nibble taken before modifier nibble
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      operation_field   <= OP_MISC;
      modifier_field   <= 4'h0;
      word2 <= 8'h00;
    end else if (state == ST_FETCH) begin
      if (ph == PH_OPR) operation_field <= rom_data[7:4];   // [RULE_01]
      if (ph == PH_OPA) modifier_field <= rom_data[3:0];   // [RULE_01]
    end else if (state == ST_SECOND) begin
      if (ph == PH_OPR) word2[7:4] <= rom_data[7:4];
      if (ph == PH_OPA) word2[3:0] <= rom_data[3:0];
    end
  end

  // -----------------------------------------------------------
  // Program counter, address and stack
  // -----------------------------------------------------------
  // Counter advances after each fetched word except the one read through pair zero, jumps at execute
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pc       <= 12'h000;
      rom_addr <= 12'h000;
      sp       <= 3'h0;
      for (int i = 0; i < STACK_DEPTH; i++) stack[i] <= 12'h000;
    end else begin
      if (state != ST_IDLE && ph == PH_ADDR) begin
        if (state == ST_SECOND && fin_second)
          rom_addr <= {pc[11:8], pair0_val};    // [RULE_08]
        else
          rom_addr <= pc;
      end
      if (state != ST_IDLE && ph == PH_OPA
          && !(state == ST_SECOND && fin_second))
        pc <= pc + 12'h001;
      if (exec1) begin
        if (operation_field == OP_IND && modifier_field[0])
          pc[7:0] <= pair_val;                  // [RULE_09]
        if (operation_field == OP_BBL) begin
          pc <= stack[sp_dn];                   // [RULE_14]
          sp <= sp_dn;
        end
      end
      if (exec2) begin
        unique case (operation_field)
          OP_JCN: if (jump_taken) pc[7:0] <= word2;    // [RULE_04]
          OP_JUN: pc <= {modifier_field, word2};                  // [RULE_10]
          OP_JMS: begin
            stack[sp] <= pc;                           // [RULE_10]
            sp        <= sp_up;
            pc        <= {modifier_field, word2};                 // [RULE_10]
          end
          OP_ISZ: if (inc_res != 4'h0) pc[7:0] <= word2; // [RULE_11]
          default: ;
        endcase
      end
    end
  end

  // -----------------------------------------------------------
  // Accumulator and carry
  // -----------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      acc <= 4'h0;
      cy  <= 1'b0;
    end else if (exec1) begin
      unique case (operation_field)
        OP_ADD: {cy, acc} <= add_res;                  // [RULE_12]
        OP_SUB: {cy, acc} <= sub_res;                  // [RULE_12]
        OP_LD:  acc <= reg_val;                        // [RULE_13]
        OP_XCH: acc <= reg_val;                        // [RULE_13]
        OP_BBL, OP_LDM: acc <= modifier_field;                    // [RULE_14]
        OP_IO: begin
          unique case (modifier_field)
            M_ADM: {cy, acc} <= add_res;               // [RULE_16]
            M_SBM: {cy, acc} <= sub_res;               // [RULE_16]
            M_RDM, M_RDR: acc <= io_data;              // [RULE_17]
            default: if (modifier_field[3:2] == 2'b11) acc <= io_data; // [RULE_18]
          endcase
        end
        OP_ACC: begin
          unique case (modifier_field)
            M_CLB: begin
              acc <= 4'h0;                             // [RULE_20]
              cy  <= 1'b0;
            end
            M_CLC: cy <= 1'b0;                         // [RULE_20]
            M_IAC: {cy, acc} <= {1'b0, acc} + 5'h01;   // [RULE_20]
            M_CMC: cy <= ~cy;                          // [RULE_20]
            M_CMA: acc <= ~acc;
            M_RAL: {cy, acc} <= {acc, cy};             // [RULE_21]
            M_RAR: {acc, cy} <= {cy, acc};             // [RULE_21]
            M_TCC: begin
              acc <= {3'h0, cy};                       // [RULE_21]
              cy  <= 1'b0;
            end
            // Carry set afterwards means no borrow occurred
            M_DAC: {cy, acc} <= {1'b0, acc} + 5'h0F;   // [RULE_22]
            M_TCS: begin
              acc <= cy ? TCS_CARRY : TCS_NOCARRY;     // [RULE_22]
              cy  <= 1'b0;
            end
            M_STC: cy <= 1'b1;
            default: ;
          endcase
        end
        default: ;
      endcase
    end
  end

  assign carry_out = cy;

  // -----------------------------------------------------------
  // Index registers and banks
  // -----------------------------------------------------------
  // Whole array clears in one reset cycle, unlike a slow refresh
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bank         <= 1'b0;
      rom_bank_sel <= 1'b0;
      for (int b = 0; b < 2; b++)
        for (int r = 0; r < 16; r++) idx[b][r] <= 4'h0;
    end else begin
      if (exec1) begin
        unique case (operation_field)
          OP_MISC: begin
            if (modifier_field == M_IDX_BANK0) bank <= 1'b0;          // [RULE_15]
            if (modifier_field == M_IDX_BANK1) bank <= 1'b1;          // [RULE_15]
            if (modifier_field == M_ROM_BANK0) rom_bank_sel <= 1'b0;
            if (modifier_field == M_ROM_BANK1) rom_bank_sel <= 1'b1;  // [RULE_15]
          end
          OP_INC: idx[bank][modifier_field] <= inc_res;
          OP_XCH: idx[bank][modifier_field] <= acc;                   // [RULE_13]
          default: ;
        endcase
      end
      if (exec2) begin
        unique case (operation_field)
          OP_PAIR, OP_IND: begin
            // Immediate and indirect fetch both land in the pair
            idx[bank][{modifier_field[3:1], 1'b0}] <= word2[7:4];     // [RULE_06] [RULE_08]
            idx[bank][{modifier_field[3:1], 1'b1}] <= word2[3:0];     // [RULE_06] [RULE_08]
          end
          OP_ISZ: idx[bank][modifier_field] <= inc_res;               // [RULE_11]
          default: ;
        endcase
      end
    end
  end

  // -----------------------------------------------------------
  // RAM/ROM port
  // -----------------------------------------------------------
  // Read request stands from phase 6 through the execute edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      src_addr <= '0;
      io_req   <= '0;
    end else begin
      if (exec1 && operation_field == OP_PAIR && modifier_field[0])
        src_addr <= pair_val;                   // [RULE_07]
      if (state == ST_FETCH && ph == PH_IORD && operation_field == OP_IO)
        io_req <= '{rd: modifier_field[3], cmd: modifier_field};      // [RULE_17] [RULE_18] [RULE_19]
      else if (ph == PH_EXEC)
        io_req <= '0;
    end
  end

  // -----------------------------------------------------------
  // APB slave
  // -----------------------------------------------------------
  // No wait state: ready is high in the first access-phase cycle after setup
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      run     <= 1'b0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        pslverr <= !(paddr == ADDR_CTRL || paddr == ADDR_STATUS
                     || paddr == ADDR_SRC);
        unique case (paddr)
          ADDR_CTRL:   prdata <= {31'h0, run};
          ADDR_STATUS: prdata <= {12'h000, pc, (state == ST_IDLE),
                                  rom_bank_sel, bank, cy, acc};
          ADDR_SRC:    prdata <= {24'h00_0000, src_addr};
          default:     prdata <= 32'h0000_0000;
        endcase
      end
      if (psel && penable && pready && pwrite && paddr == ADDR_CTRL)
        run <= pwdata[CTRL_RUN];
    end
  end
endmodule

// [pkg/nibble_core_pkg.sv]
// Constants and carrier types for the nibble processor core
package nibble_core_pkg;
  // -----------------------------------------------------------
  // Instruction cycle phases (eight clocks per word)
  // -----------------------------------------------------------
  localparam logic [2:0] PH_ADDR = 3'h0;
  localparam logic [2:0] PH_OPR  = 3'h3;
  localparam logic [2:0] PH_OPA  = 3'h4;
  localparam logic [2:0] PH_IORD = 3'h5;
  localparam logic [2:0] PH_EXEC = 3'h7;
  // -----------------------------------------------------------
  // Operation field codes
  // -----------------------------------------------------------
  localparam logic [3:0] OP_MISC = 4'h0;
  localparam logic [3:0] OP_JCN  = 4'h1;
  localparam logic [3:0] OP_PAIR = 4'h2;
  localparam logic [3:0] OP_IND  = 4'h3;
  localparam logic [3:0] OP_JUN  = 4'h4;
  localparam logic [3:0] OP_JMS  = 4'h5;
  localparam logic [3:0] OP_INC  = 4'h6;
  localparam logic [3:0] OP_ISZ  = 4'h7;
  localparam logic [3:0] OP_ADD  = 4'h8;
  localparam logic [3:0] OP_SUB  = 4'h9;
  localparam logic [3:0] OP_LD   = 4'hA;
  localparam logic [3:0] OP_XCH  = 4'hB;
  localparam logic [3:0] OP_BBL  = 4'hC;
  localparam logic [3:0] OP_LDM  = 4'hD;
  localparam logic [3:0] OP_IO   = 4'hE;
  localparam logic [3:0] OP_ACC  = 4'hF;
  // -----------------------------------------------------------
  // Modifier codes: machine, I/O and accumulator groups
  // -----------------------------------------------------------
  localparam logic [3:0] M_ROM_BANK0 = 4'h8;
  localparam logic [3:0] M_ROM_BANK1 = 4'h9;
  localparam logic [3:0] M_IDX_BANK0 = 4'hA;
  localparam logic [3:0] M_IDX_BANK1 = 4'hB;
  localparam logic [3:0] M_SBM = 4'h8;
  localparam logic [3:0] M_RDM = 4'h9;
  localparam logic [3:0] M_RDR = 4'hA;
  localparam logic [3:0] M_ADM = 4'hB;
  localparam logic [3:0] M_CLB = 4'h0;
  localparam logic [3:0] M_CLC = 4'h1;
  localparam logic [3:0] M_IAC = 4'h2;
  localparam logic [3:0] M_CMC = 4'h3;
  localparam logic [3:0] M_CMA = 4'h4;
  localparam logic [3:0] M_RAL = 4'h5;
  localparam logic [3:0] M_RAR = 4'h6;
  localparam logic [3:0] M_TCC = 4'h7;
  localparam logic [3:0] M_DAC = 4'h8;
  localparam logic [3:0] M_TCS = 4'h9;
  localparam logic [3:0] M_STC = 4'hA;
  localparam logic [3:0] TCS_CARRY   = 4'hA;
  localparam logic [3:0] TCS_NOCARRY = 4'h9;
  // -----------------------------------------------------------
  // APB register map (byte addresses)
  // -----------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SRC    = 8'h08;
  localparam int         CTRL_RUN    = 0;
  // -----------------------------------------------------------
  // Carriers
  // -----------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_FETCH  = 3'b010,
    ST_SECOND = 3'b100
  } core_state_e;
  typedef struct packed {
    logic [1:0] chip;
    logic [1:0] regn;
    logic [3:0] chr;
  } src_addr_s;
  typedef struct packed {
    logic       rd;
    logic [3:0] cmd;
  } io_req_s;
endpackage

// [tb/nibble_core_sva.sv]
// Timing and protocol checker bound to the nibble processor core
`timescale 1ns/1ns
module nibble_core_sva
  import nibble_core_pkg::*;
(
  input wire logic        sys_clk,    // System clock
  input wire logic        rst_n,      // Synchronous reset, active low
  input wire logic        psel,       // APB select
  input wire logic        penable,    // APB access phase
  input wire logic [7:0]  paddr,      // APB byte address
  input wire logic        pready,     // APB ready
  input wire logic        pslverr,    // APB error
  input wire logic [11:0] rom_addr,   // Program address
  input wire io_req_s     io_req,     // Read request and code
  input wire logic        carry_out,  // Carry flag
  input wire logic        sync_out    // Word cycle start
);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Read strobe holds one more cycle, then drops at the execute edge
  sequence s_rd_window;
    io_req.rd ##1 !io_req.rd;
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_slverr_map: assert property (pready |-> pslverr ==
      (paddr != ADDR_CTRL && paddr != ADDR_STATUS && paddr != ADDR_SRC))
    else $error("pslverr disagrees with address map");
  a_sync_spacing: assert property (sync_out |=> !sync_out [*7])
    else $error("word cycle shorter than eight clocks");
  a_fetch_at_sync: assert property (!$stable(rom_addr) |-> $past(sync_out))
    else $error("program address moved outside phase 0");
  a_io_read_window: assert property ($rose(io_req.rd) |-> ##1 s_rd_window)
    else $error("read strobe not two cycles");
  a_io_read_code: assert property (io_req.rd |-> io_req.cmd[3])
    else $error("read strobe with a non-read code");
  a_io_read_phase: assert property ($rose(io_req.rd) |-> $past(sync_out, 6))
    else $error("read strobe rose outside phase 6");
  a_carry_at_exec: assert property (!$stable(carry_out) |-> $past(sync_out, 8))
    else $error("carry changed outside the execute edge");
endmodule

bind nibble_core nibble_core_sva u_sva (
  .sys_clk, .rst_n, .psel, .penable, .paddr, .pready, .pslverr,
  .rom_addr, .io_req, .carry_out, .sync_out
);

// [tb/nibble_mem_model.sv]
// Program ROM and data RAM model on the core's memory side
`timescale 1ns/1ns
module nibble_mem_model
  import nibble_core_pkg::*;
#(
  parameter logic [3:0] PORT_VAL = 4'hC  // ROM input port pattern
) (
  input  wire logic [11:0] rom_addr,  // Program address
  input  wire logic        sys_clk,   // System clock
  output logic      [7:0]  rom_data,  // Program word
  input  wire src_addr_s   src_addr,  // Sent chip, register, character
  input  wire io_req_s     io_req,    // Read request
  output logic      [3:0]  io_data    // Read data
);
  logic [7:0] rom [4096];
  logic [3:0] ram [512];
  logic [3:0] idle_pat = 4'h0;
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Four registers per chip, sixteen main plus four status characters
  initial begin
    for (int k = 0; k < 512; k++) begin
      ram[k] = 4'(k) ^ 4'(k >> 5);
    end
  end
  // Slow answer: word lags the address a cycle, still before phase 3
  always_ff @(posedge sys_clk) begin
    rom_data <= rom[rom_addr];
    idle_pat <= idle_pat + 4'h7;
  end
  // Released lines show a moving pattern, never the last value
  always_comb begin
    if (!io_req.rd)
      io_data = idle_pat;
    else if (io_req.cmd == M_RDR)
      io_data = PORT_VAL ^ {src_addr.chip, src_addr.regn};
    else if (io_req.cmd[2])
      io_data = ram[{src_addr.chip, src_addr.regn, 3'b100, io_req.cmd[1:0]}];
    else
      io_data = ram[{src_addr.chip, src_addr.regn, 1'b0, src_addr.chr}];
  end
endmodule

// [tb/nibble_core_tb_top.sv]
// Self-checking bench for the nibble processor core
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module nibble_core_tb_top
  import nibble_core_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        test_in = 1'b0;  // Low, so the test-input condition jumps
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] rom_addr;
  logic [7:0]  rom_data;
  src_addr_s   src_addr;
  io_req_s     io_req;
  logic [3:0]  io_data;
  logic        rom_bank_sel;
  logic [31:0] rdat;
  logic        err;
  logic        carry_pin;
  logic        sync_pin;
  int          errors = 0;
  int          n_compared = 0;
  // ----------------------------------------------------------------
  // Clock, design and memory
  // ----------------------------------------------------------------
  always #50 sys_clk = ~sys_clk;
  nibble_core dut (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rom_addr, .rom_data, .src_addr, .io_req,
    .io_data, .test_in, .rom_bank_sel, .carry_out(carry_pin), .sync_out(sync_pin));
  nibble_mem_model u_mem (.sys_clk, .rom_addr, .rom_data, .src_addr, .io_req, .io_data);
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Verdict; also the exit for any wait that runs out
  task automatic complete_run;
    $display("COUNTS compared=%0d mismatches=%0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      complete_run();
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Run a program to its self-jump, stop at a boundary, check status
  task automatic run_prog(input logic [7:0] p[$], input logic [11:0] halt,
                          input logic [19:0] exp);
    int n;
    do_reset();
    for (int i = 0; i < 4096; i++) u_mem.rom[i] = (i < p.size()) ? p[i] : 8'h00;
    apb(1'b1, ADDR_CTRL, 32'h1);
    n = 0;
    while (rom_addr !== halt && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 3000) begin
      errors++;
      complete_run();
    end
    apb(1'b1, ADDR_CTRL, 32'h0);
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (rdat[7] !== 1'b1 && n < 50);
    if (rdat[7] !== 1'b1) begin
      errors++;
      complete_run();
    end
    `CHK(rdat[19:0], exp)
    $display("TEST program to %h done", halt);
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK(rdat, 32'h0)
    apb(1'b1, ADDR_STATUS, 32'hFFFFFFFF);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rdat, 32'h80)
    apb(1'b0, 8'h0C, 32'h0);
    `CHK({err, rdat}, 33'h100000000)
    $display("TEST registers done");
    // Accumulator group chain
    run_prog('{8'hD5, 8'hF2, 8'hF3, 8'hF5, 8'hF8, 8'hF9, 8'hF6, 8'hF3, 8'hF7,
      8'h40, 8'h09}, 12'h009, 20'h00981);
    `CHK(carry_pin, 1'b0)
    `CHK(sync_pin, 1'b0)
    // Pair load, add and subtract, swap, bank switching
    run_prog('{8'h20, 8'h37, 8'hD9, 8'h81, 8'h90, 8'hB2, 8'h0B, 8'hA2, 8'h0A, 8'hA2,
      8'h09, 8'h40, 8'h0B}, 12'h00B, 20'h00BCC);
    `CHK(rom_bank_sel, 1'b1)
    // Call, conditions, indirect fetch, RAM and port reads, skip loop
    run_prog('{8'h50, 8'h08, 8'h14, 8'h0A, 8'h11, 8'h0C, 8'h00, 8'h00, 8'hC3, 8'h00,
      8'h00, 8'h00, 8'h20, 8'h20, 8'h32, 8'h23, 8'hE9, 8'hB4, 8'hEF, 8'h84, 8'hEB,
      8'hE8, 8'hB8, 8'hEA, 8'h75, 8'h18, 8'h26, 8'h1E, 8'h37, 8'hD0, 8'h40, 8'h1E,
      8'h5A}, 12'h01E, 20'h01E89);
    `CHK(src_addr, 8'h5A)
    complete_run();
  end
endmodule
